// >>> src/ssbp_pkg.sv
`default_nettype none

package ssbp_pkg;

    // ------------------------------------------------------------
    // Field widths and limits
    // ------------------------------------------------------------
    localparam int CB_W        = 6;
    localparam int CB_MAX      = 36;
    localparam int BLK_W       = 4;
    localparam int IDX_MUL     = 4;
    localparam int COST_MUL    = 5;
    localparam int IDX_W       = IDX_MUL * CB_MAX;
    localparam int EXCESS_BITS = 4 * CB_MAX;
    localparam int EXL_W       = 8;
    localparam int MAX_TRACKS  = 4;
    localparam int PTR_W       = 16;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic signed [PTR_W-1:0] ssbp_ptr_t;

    typedef enum logic [1:0] {
        SSBP_FRAME_256  = 2'h0,
        SSBP_FRAME_512  = 2'h1,
        SSBP_FRAME_1024 = 2'h2
    } ssbp_frame_t;

    typedef enum logic [2:0] {
        SSBP_IDLE  = 3'h0,
        SSBP_LOAD  = 3'h1,
        SSBP_CODES = 3'h3,
        SSBP_INDEX = 3'h2,
        SSBP_SPILL = 3'h6,
        SSBP_DONE  = 3'h7
    } ssbp_state_t;

endpackage

`default_nettype wire

// >>> src/ssbp_tbl_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ssbp_tbl_if #(
    parameter int AW = 7
);
    logic          clr;
    logic          bit_we;
    logic [AW+1:0] bit_addr;
    logic          bit_val;
    logic          word_we;
    logic [AW-1:0] word_addr;
    logic [3:0]    word_data;
    logic [AW-1:0] rd_addr;
    logic [3:0]    rd_data;

    modport owner (
        output clr, bit_we, bit_addr, bit_val, word_we, word_addr, word_data, rd_addr,
        input  rd_data
    );
    modport tbl (
        input  clr, bit_we, bit_addr, bit_val, word_we, word_addr, word_data, rd_addr,
        output rd_data
    );
endinterface

`default_nettype wire

// >>> src/ssbp_pkt_table.sv
`timescale 1ns/1ps
`default_nettype none

module ssbp_pkt_table #(
    parameter int AW = 7
) (
    input  wire logic clk,
    input  wire logic arst_n,
    ssbp_tbl_if.tbl   tb
);

    // ------------------------------------------------------------
    // Packet storage, 4-bit words
    // ------------------------------------------------------------
    logic [3:0] mem [2**AW];
    logic [3:0] rd_data_reg;

    always_ff @(posedge clk) begin
        if (tb.clr) begin
            for (int w = 0; w < 2**AW; w++) begin
                mem[w] <= 4'h0;
            end
        end else if (tb.word_we) begin
            mem[tb.word_addr] <= tb.word_data;
        end else if (tb.bit_we) begin
            mem[tb.bit_addr[AW+1:2]][tb.bit_addr[1:0]] <= tb.bit_val;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_reg <= 4'h0;
        end else begin
            rd_data_reg <= mem[tb.rd_addr];
        end
    end

    assign tb.rd_data = rd_data_reg;

endmodule

`default_nettype wire

// >>> src/ssbp_packer.sv
// Operation
// - Emit one, two or four packets for 256, 512, 1024-sample frames.
// - Track is split number modulo track count; one track holds all.
// - Each split is one 8-dimensional vector owned by one track.
// - A split's bits are never divided between tracks at assignment.
// - Lattice index is four times the codebook number in bits.
// - Packet order follows track order.
// - Splits of a track are written lowest frequency first.
// - Codebook number n coded as n-1 ones then a zero.
// - Codebook zero still takes one zero bit and no index.
// - A coded split costs five times its codebook number; the budget check charges five times it minus one.
// - Codes written downward from table end, indices upward from zero.
// - Index pointer starts at zero rising; code pointer at size-1 falling.
// - Free bits equal code pointer minus index pointer plus one.
// - Table cleared to zero before writing.
// - Split written only if minimum cost fits the free bit count.
// - Overflow detected when index and code writes would collide.
// - Two packets: excess bits go to the other packet's gap.
// - Four packets: gaps pooled and excess placed into the pool.
// - Every packet ends completely filled and decodable; the code leaves unused gap bits at the cleared zero, with no padding.
// - Table stored as 4-bit words; index pointer multiple of four.
// - Excess buffer of four times 36 bits holds overflow bits.
`timescale 1ns/1ps
`default_nettype none

module ssbp_packer #(
    parameter int PKT_BITS_MAX = 512,
    parameter int MAX_SPLITS   = 128,
    localparam int AW          = $clog2(PKT_BITS_MAX / 4),
    localparam int KW          = $clog2(MAX_SPLITS)
) (
    input  wire logic                             clk,
    input  wire logic                             arst_n,
    input  wire logic                             start,
    input  wire logic [1:0]                       frame_sel,
    input  wire logic [ssbp_pkg::PTR_W-1:0]       pkt_bits,
    input  wire logic                             split_valid,
    output logic                                  split_ready,
    input  wire logic [ssbp_pkg::CB_W-1:0]        split_cb,
    input  wire logic [ssbp_pkg::IDX_W-1:0]       split_idx,
    input  wire logic                             split_last,
    output logic                                  busy,
    output logic                                  done,
    output logic                                  overflow,
    output logic [2:0]                            pkt_count,
    input  wire logic [1:0]                       rd_pkt,
    input  wire logic [AW-1:0]                    rd_addr,
    output logic [3:0]                            rd_data
);

    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    ssbp_pkg::ssbp_state_t       state_reg;
    ssbp_pkg::ssbp_ptr_t         pos_i_reg [ssbp_pkg::MAX_TRACKS];
    ssbp_pkg::ssbp_ptr_t         pos_n_reg [ssbp_pkg::MAX_TRACKS];
    ssbp_pkg::ssbp_ptr_t         free_bit_count_reg;
    ssbp_pkg::ssbp_ptr_t         free_bits [ssbp_pkg::MAX_TRACKS];
    logic [ssbp_pkg::CB_W-1:0]   cb_mem    [MAX_SPLITS];
    logic [ssbp_pkg::IDX_W-1:0]  idx_mem   [MAX_SPLITS];
    logic [KW:0]                 cnt_reg;
    logic [KW-1:0]               k_reg;
    logic [ssbp_pkg::CB_W-1:0]   bit_reg;
    logic [ssbp_pkg::EXCESS_BITS-1:0] excess_bit_buffer_reg;
    logic [ssbp_pkg::EXL_W-1:0]  ex_len_reg;
    logic [ssbp_pkg::EXL_W-1:0]  ex_rd_reg;
    logic [1:0]                  trk_mask_reg;
    logic [2:0]                  pkt_count_reg;
    logic                        done_reg;
    logic                        overflow_reg;
    logic [1:0]                  rd_pkt_q;
    logic [3:0]                  rd_data_reg;

    // ------------------------------------------------------------
    // Step decode
    // ------------------------------------------------------------
    logic                        take;
    logic                        fits;
    ssbp_pkg::ssbp_ptr_t         cost;
    logic [1:0]                  trk;
    logic [ssbp_pkg::CB_W-1:0]   cb_cur;
    logic [ssbp_pkg::CB_W-1:0]   ones;
    logic                        codes_one;
    logic                        codes_step;
    logic                        idx_step;
    logic                        idx_fit;
    logic                        idx_end;
    logic                        spill_step;
    logic                        spill_end;
    logic                        spill_ok;
    logic [1:0]                  spill_q;
    logic                        last_k;
    logic [3:0]                  blk;
    logic [2:0]                  tracks;

    always_comb begin
        unique case (frame_sel)
            ssbp_pkg::SSBP_FRAME_256:  tracks = 3'h1;
            ssbp_pkg::SSBP_FRAME_512:  tracks = 3'h2;
            default:                   tracks = 3'h4;
        endcase
    end

    assign take        = split_valid && split_ready;
    assign split_ready = (state_reg == ssbp_pkg::SSBP_LOAD);
    // Value one never arrives; cost is five times n minus one, one below the n code and 4n index bits written
    assign cost = (split_cb == '0) ? '0
                : ssbp_pkg::ssbp_ptr_t'(ssbp_pkg::COST_MUL * int'(split_cb) - 1);
    assign fits = (cost <= free_bit_count_reg);

    assign trk    = k_reg[1:0] & trk_mask_reg;
    assign cb_cur = cb_mem[k_reg];
    assign ones   = (cb_cur == '0) ? '0 : cb_cur - 6'h01;
    assign last_k = ({1'b0, k_reg} == cnt_reg - 1'b1);
    assign blk    = idx_mem[k_reg][ssbp_pkg::BLK_W * int'(bit_reg) +: ssbp_pkg::BLK_W];

    for (genvar p = 0; p < ssbp_pkg::MAX_TRACKS; p++) begin : g_free
        assign free_bits[p] = pos_n_reg[p] - pos_i_reg[p] + 16'sh0001;
    end

    assign codes_step = (state_reg == ssbp_pkg::SSBP_CODES);
    assign codes_one  = codes_step && (bit_reg < ones);
    assign idx_step   = (state_reg == ssbp_pkg::SSBP_INDEX) && (cb_cur != '0) && (bit_reg < cb_cur);
    assign idx_fit    = idx_step && (free_bits[trk] >= 16'sh0004);
    assign idx_end    = (state_reg == ssbp_pkg::SSBP_INDEX) && !idx_step;
    assign spill_step = (state_reg == ssbp_pkg::SSBP_SPILL) && (ex_rd_reg < ex_len_reg);
    assign spill_end  = (state_reg == ssbp_pkg::SSBP_SPILL) && !spill_step;

    // Pick the first other packet with a gap, own leftover bits last
    always_comb begin
        spill_ok = 1'b0;
        spill_q  = trk;
        for (int q = 0; q < ssbp_pkg::MAX_TRACKS; q++) begin
            if (!spill_ok && (3'(q) < tracks) && (2'(q) != trk) && (free_bits[q] > 0)) begin
                spill_ok = 1'b1;
                spill_q  = 2'(q);
            end
        end
        if (!spill_ok && (free_bits[trk] > 0)) begin
            spill_ok = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ssbp_pkg::SSBP_IDLE;
        end else begin
            unique case (state_reg)
                ssbp_pkg::SSBP_IDLE:  if (start) state_reg <= ssbp_pkg::SSBP_LOAD;
                ssbp_pkg::SSBP_LOAD: begin
                    if (take && (split_last || cnt_reg == (KW+1)'(MAX_SPLITS - 1))) begin
                        state_reg <= ssbp_pkg::SSBP_CODES;
                    end
                end
                ssbp_pkg::SSBP_CODES: begin
                    if (!codes_one && last_k) state_reg <= ssbp_pkg::SSBP_INDEX;
                end
                ssbp_pkg::SSBP_INDEX: begin
                    if (idx_end && ex_len_reg != '0) begin
                        state_reg <= ssbp_pkg::SSBP_SPILL;
                    end else if (idx_end && last_k) begin
                        state_reg <= ssbp_pkg::SSBP_DONE;
                    end
                end
                ssbp_pkg::SSBP_SPILL: begin
                    if (spill_end) begin
                        state_reg <= last_k ? ssbp_pkg::SSBP_DONE : ssbp_pkg::SSBP_INDEX;
                    end
                end
                ssbp_pkg::SSBP_DONE:  state_reg <= ssbp_pkg::SSBP_IDLE;
                default:              state_reg <= ssbp_pkg::SSBP_IDLE;
            endcase
        end
    end

    // Split and bit counters walk each track in rising split order
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            k_reg   <= '0;
            bit_reg <= '0;
        end else if (state_reg == ssbp_pkg::SSBP_IDLE || state_reg == ssbp_pkg::SSBP_LOAD) begin
            k_reg   <= '0;
            bit_reg <= '0;
        end else if (codes_one || idx_step) begin
            bit_reg <= bit_reg + 6'h01;
        end else if (codes_step || (idx_end && ex_len_reg == '0) || spill_end) begin
            k_reg   <= last_k ? '0 : k_reg + 1'b1;
            bit_reg <= '0;
        end
    end

    // ------------------------------------------------------------
    // Intake and bit budget
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            free_bit_count_reg <= '0;
            cnt_reg            <= '0;
            trk_mask_reg       <= '0;
            pkt_count_reg      <= '0;
        end else if (state_reg == ssbp_pkg::SSBP_IDLE && start) begin
            free_bit_count_reg <= ssbp_pkg::ssbp_ptr_t'(int'(tracks) * int'(pkt_bits));
            cnt_reg            <= '0;
            trk_mask_reg       <= 2'(tracks - 3'h1);
            pkt_count_reg      <= tracks;
        end else if (take) begin
            cnt_reg <= cnt_reg + 1'b1;
            if (fits) begin
                free_bit_count_reg <= free_bit_count_reg - cost;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (take) begin
            cb_mem[cnt_reg[KW-1:0]]  <= fits ? split_cb : '0;
            idx_mem[cnt_reg[KW-1:0]] <= split_idx;
        end
    end

    // ------------------------------------------------------------
    // Packet pointers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int p = 0; p < ssbp_pkg::MAX_TRACKS; p++) begin
                pos_i_reg[p] <= '0;
                pos_n_reg[p] <= '0;
            end
        end else if (state_reg == ssbp_pkg::SSBP_IDLE && start) begin
            for (int p = 0; p < ssbp_pkg::MAX_TRACKS; p++) begin
                pos_i_reg[p] <= '0;
                pos_n_reg[p] <= ssbp_pkg::ssbp_ptr_t'(pkt_bits) - 16'sh0001;
            end
        end else if (codes_step) begin
            pos_n_reg[trk] <= pos_n_reg[trk] - 16'sh0001;
        end else if (idx_fit) begin
            pos_i_reg[trk] <= pos_i_reg[trk] + 16'sh0004;
        end else if (spill_step && spill_ok) begin
            pos_n_reg[spill_q] <= pos_n_reg[spill_q] - 16'sh0001;
        end
    end

    // ------------------------------------------------------------
    // Excess buffer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            excess_bit_buffer_reg <= '0;
            ex_len_reg            <= '0;
            ex_rd_reg             <= '0;
            overflow_reg          <= 1'b0;
        end else if (state_reg == ssbp_pkg::SSBP_IDLE && start) begin
            ex_len_reg   <= '0;
            ex_rd_reg    <= '0;
            overflow_reg <= 1'b0;
        end else if (idx_step && !idx_fit) begin
            excess_bit_buffer_reg[ex_len_reg +: ssbp_pkg::BLK_W] <= blk;
            ex_len_reg   <= ex_len_reg + 8'h04;
            overflow_reg <= 1'b1;
        end else if (spill_step) begin
            ex_rd_reg <= ex_rd_reg + 8'h01;
        end else if (spill_end) begin
            ex_len_reg <= '0;
            ex_rd_reg  <= '0;
        end
    end

    // ------------------------------------------------------------
    // Packet tables
    // ------------------------------------------------------------
    logic [3:0]    rd_word [ssbp_pkg::MAX_TRACKS];
    logic [3:0]    bit_we_vec;
    logic [3:0]    word_we_vec;
    logic [AW+1:0] bit_addr_c;
    logic          bit_val_c;

    always_comb begin
        bit_we_vec  = '0;
        word_we_vec = '0;
        bit_addr_c  = pos_n_reg[trk][AW+1:0];
        bit_val_c   = 1'b1;
        if (codes_one) begin
            bit_we_vec[trk] = 1'b1;
        end else if (idx_fit) begin
            word_we_vec[trk] = 1'b1;
        end else if (spill_step && spill_ok) begin
            bit_we_vec[spill_q] = 1'b1;
            bit_addr_c          = pos_n_reg[spill_q][AW+1:0];
            bit_val_c           = excess_bit_buffer_reg[ex_rd_reg];
        end
    end

    ssbp_tbl_if #(.AW(AW)) tif [ssbp_pkg::MAX_TRACKS] ();

    for (genvar g = 0; g < ssbp_pkg::MAX_TRACKS; g++) begin : g_tbl
        assign tif[g].clr       = (state_reg == ssbp_pkg::SSBP_IDLE) && start;
        assign tif[g].bit_we    = bit_we_vec[g];
        assign tif[g].bit_addr  = bit_addr_c;
        assign tif[g].bit_val   = bit_val_c;
        assign tif[g].word_we   = word_we_vec[g];
        assign tif[g].word_addr = pos_i_reg[g][AW+1:2];
        assign tif[g].word_data = blk;
        assign tif[g].rd_addr   = rd_addr;
        assign rd_word[g]       = tif[g].rd_data;
        ssbp_pkt_table #(.AW(AW)) u_tbl (
            .clk    (clk),
            .arst_n (arst_n),
            .tb     (tif[g])
        );
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            done_reg    <= 1'b0;
            rd_pkt_q    <= '0;
            rd_data_reg <= '0;
        end else begin
            done_reg    <= (state_reg == ssbp_pkg::SSBP_DONE);
            rd_pkt_q    <= rd_pkt;
            rd_data_reg <= rd_word[rd_pkt_q];
        end
    end

    assign busy      = (state_reg != ssbp_pkg::SSBP_IDLE);
    assign done      = done_reg;
    assign overflow  = overflow_reg;
    assign pkt_count = pkt_count_reg;
    assign rd_data   = rd_data_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_pkt_count: assert property (@(posedge clk) disable iff (!arst_n)
        (state_reg == ssbp_pkg::SSBP_IDLE && start && frame_sel == 2'h2) |=> pkt_count == 3'h4)
        else $error("four packets expected for long frame");

    a_track_route: assert property (@(posedge clk) disable iff (!arst_n)
        (state_reg == ssbp_pkg::SSBP_CODES && bit_we_vec != '0)
            |-> (bit_we_vec == (4'h1 << (k_reg[1:0] & trk_mask_reg))))
        else $error("code bit written to wrong track");

    a_cost_skip: assert property (@(posedge clk) disable iff (!arst_n)
        (take && cost > free_bit_count_reg) |=> cb_mem[$past(cnt_reg[KW-1:0])] == '0)
        else $error("unfitting split not zeroed");

    a_budget_use: assert property (@(posedge clk) disable iff (!arst_n)
        (take && cost <= free_bit_count_reg)
            |=> free_bit_count_reg == $past(free_bit_count_reg) - $past(cost))
        else $error("free bit count not reduced by cost");

    a_stop_bit: assert property (@(posedge clk) disable iff (!arst_n)
        (codes_step && !codes_one && trk == 2'h0)
            |-> bit_we_vec == '0 ##1 pos_n_reg[0] == $past(pos_n_reg[0]) - 16'sh0001)
        else $error("stop bit did not consume one position");

    a_clear_init: assert property (@(posedge clk) disable iff (!arst_n)
        (state_reg == ssbp_pkg::SSBP_IDLE && start)
            |-> tif[0].clr ##1 (pos_i_reg[0] == '0
                && pos_n_reg[0] == ssbp_pkg::ssbp_ptr_t'($past(pkt_bits)) - 16'sh0001))
        else $error("table not cleared or pointers not set");

    a_idx_align: assert property (@(posedge clk) disable iff (!arst_n)
        pos_i_reg[0][1:0] == 2'h0 && pos_i_reg[1][1:0] == 2'h0)
        else $error("index pointer off word grid");

    a_no_collide: assert property (@(posedge clk) disable iff (!arst_n)
        idx_fit |-> ##1 free_bits[$past(trk)] >= 16'sh0000)
        else $error("index write ran into code area");

    a_excess_cap: assert property (@(posedge clk) disable iff (!arst_n)
        ex_len_reg <= 8'h90)
        else $error("excess buffer exceeded");

    a_split_order: assert property (@(posedge clk) disable iff (!arst_n)
        (codes_step && $past(state_reg) == ssbp_pkg::SSBP_CODES && k_reg != $past(k_reg))
            |-> k_reg == $past(k_reg) + 1'b1)
        else $error("splits not written in rising order");

    a_done_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        done |=> !done && !busy)
        else $error("done not a single pulse");

endmodule

`default_nettype wire

// >>> bench/ssbp_split_src.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Quantizer side of the split handshake
// ------------------------------------------------------------
module ssbp_split_src (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  go,
    input  wire logic                  slow,
    input  wire logic [2:0]            n_last,
    input  wire logic [7:0][5:0]       cb_tab,
    input  wire logic [7:0][15:0]      idx_tab,
    input  wire logic                  split_ready,
    output logic                       split_valid,
    output logic [ssbp_pkg::CB_W-1:0]  split_cb,
    output logic [ssbp_pkg::IDX_W-1:0] split_idx,
    output logic                       split_last
);
    logic       active_reg;
    logic       gap_reg;
    logic [2:0] k_reg;

    // Idle lines show the inverse of the held value
    assign split_valid = active_reg && !gap_reg;
    assign split_cb    = split_valid ? cb_tab[k_reg] : ~cb_tab[k_reg];
    assign split_idx   = {128'h0, split_valid ? idx_tab[k_reg] : ~idx_tab[k_reg]};
    assign split_last  = split_valid && (k_reg == n_last);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            active_reg <= 1'b0;
            gap_reg    <= 1'b0;
            k_reg      <= 3'h0;
        end else if (go) begin
            active_reg <= 1'b1;
            gap_reg    <= 1'b0;
            k_reg      <= 3'h0;
        end else if (split_valid && split_ready) begin
            gap_reg <= slow;
            if (k_reg == n_last) begin
                active_reg <= 1'b0;
            end else begin
                k_reg <= k_reg + 3'h1;
            end
        end else begin
            gap_reg <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// >>> bench/spectral_split_bit_packer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module spectral_split_bit_packer_tb;
    logic clk, arst_n, start, go, slow, split_valid, split_ready, split_last, busy, done, overflow;
    logic [1:0]   frame_sel, rd_pkt;
    logic [15:0]  pkt_bits;
    logic [5:0]   split_cb;
    logic [143:0] split_idx;
    logic [2:0]   pkt_count, n_last;
    logic [3:0]   rd_addr, rd_data;
    logic [7:0][5:0]  cb_tab;
    logic [7:0][15:0] idx_tab;
    int num_errors, compares;

    ssbp_packer #(.PKT_BITS_MAX(64), .MAX_SPLITS(16)) uut (.clk(clk), .arst_n(arst_n),
        .start(start), .frame_sel(frame_sel), .pkt_bits(pkt_bits), .split_valid(split_valid),
        .split_ready(split_ready), .split_cb(split_cb), .split_idx(split_idx),
        .split_last(split_last), .busy(busy), .done(done), .overflow(overflow),
        .pkt_count(pkt_count), .rd_pkt(rd_pkt), .rd_addr(rd_addr), .rd_data(rd_data));
    ssbp_split_src src (.clk(clk), .arst_n(arst_n), .go(go), .slow(slow), .n_last(n_last),
        .cb_tab(cb_tab), .idx_tab(idx_tab), .split_ready(split_ready),
        .split_valid(split_valid), .split_cb(split_cb), .split_idx(split_idx),
        .split_last(split_last));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [1:0] p, input logic [3:0] a, input logic [3:0] exp);
        @(posedge clk);
        rd_pkt  <= p;
        rd_addr <= a;
        repeat (3) @(posedge clk);
        #1;
        check(rd_data, exp);
    endtask

    task automatic run_frame(input logic [1:0] sel, input logic [15:0] bits,
                             input logic [2:0] last, input logic s);
        int i;
        @(posedge clk);
        start     <= 1'b1;
        go        <= 1'b1;
        frame_sel <= sel;
        pkt_bits  <= bits;
        n_last    <= last;
        slow      <= s;
        @(posedge clk);
        start <= 1'b0;
        go    <= 1'b0;
        for (i = 0; i < 2000 && done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check({3'h0, done}, 4'h1);
        check({3'h0, busy}, 4'h0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_tracks(input logic [1:0] sel, input logic [2:0] cnt);
        int p;
        for (p = 0; p < 4; p++) begin
            cb_tab[p]  = 6'h02;
            idx_tab[p] = {8'h00, 4'(p + 8), 4'(p + 1)};
        end
        run_frame(sel, 16'h0040, 3'h3, 1'b0);
        check({1'b0, pkt_count}, {1'b0, cnt});
        check({3'h0, overflow}, 4'h0);
        for (p = 0; p < int'(cnt); p++) begin
            rdc(2'(p), 4'hf, (cnt == 3'h4) ? 4'h8 : 4'ha);
            rdc(2'(p), 4'h0, 4'(p + 1));
            rdc(2'(p), 4'h1, 4'(p + 8));
            rdc(2'(p), 4'h2, (cnt == 3'h4) ? 4'h0 : 4'(p + 1 + int'(cnt)));
        end
        if (cnt == 3'h1) begin
            rdc(2'h0, 4'he, 4'ha);
        end
    endtask

    task automatic test_refuse();
        cb_tab[2:0]  = {6'h02, 6'h03, 6'h00};
        idx_tab[2:0] = {16'h00ff, 16'h0b4d, 16'h0000};
        run_frame(2'h0, 16'h0014, 3'h2, 1'b1);
        rdc(2'h0, 4'h4, 4'h6);
        rdc(2'h0, 4'h0, 4'hd);
        rdc(2'h0, 4'h2, 4'hb);
        rdc(2'h0, 4'h3, 4'h0);
        check({3'h0, overflow}, 4'h0);
    endtask

    task automatic test_overflow();
        cb_tab[2:0]  = {6'h02, 6'h00, 6'h03};
        idx_tab[2:0] = {16'h0055, 16'h0000, 16'h0321};
        run_frame(2'h1, 16'h0010, 3'h2, 1'b0);
        check({3'h0, overflow}, 4'h1);
        rdc(2'h0, 4'h3, 4'hd);
        rdc(2'h0, 4'h0, 4'h1);
        rdc(2'h0, 4'h1, 4'h2);
        rdc(2'h1, 4'h3, 4'h6);
    endtask

    task automatic final_report();
        $display("num_errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #(100_000 * 100);
        num_errors++;
        final_report();
    end

    initial begin
        {arst_n, start, go, slow, frame_sel, pkt_bits, n_last, rd_pkt, rd_addr} = '0;
        cb_tab  = '0;
        idx_tab = '0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        check({busy, done, split_ready, overflow}, 4'h0);
        test_tracks(2'h1, 3'h2);
        test_tracks(2'h2, 3'h4);
        test_tracks(2'h0, 3'h1);
        test_tracks(2'h3, 3'h4);
        test_refuse();
        test_overflow();
        final_report();
    end
endmodule

`default_nettype wire
